// ### i2cs_regs.svh
`ifndef I2CS_REGS_SVH
`define I2CS_REGS_SVH

// Register offsets on the local register port
`define I2CS_OFS_CTRL1 8'hD9
`define I2CS_OFS_CTRL2 8'hDA
`define I2CS_OFS_CTRL3 8'hDB
`define I2CS_OFS_CTRL4 8'hDC
`define I2CS_OFS_SAR 8'hDD
`define I2CS_OFS_STAT1 8'hE1
`define I2CS_OFS_STAT2 8'hE2
`define I2CS_OFS_BAUD 8'hE3
`define I2CS_OFS_HOLD 8'hE4
`define I2CS_OFS_DATA 8'hE5
`define I2CS_OFS_SCLL 8'hE6
`define I2CS_OFS_SCLH 8'hE7

// Reset values
`define I2CS_RST_CTRL 8'h00
`define I2CS_RST_SAR 8'h00
`define I2CS_RST_STAT1 8'h80
`define I2CS_RST_BAUD 8'hFF
`define I2CS_RST_HOLD 8'h01
`define I2CS_RST_DATA 8'h00
`define I2CS_RST_SCLP 8'h3F

// Field positions
`define I2CS_CR1_MODE_HI 7
`define I2CS_CR1_MODE_LO 6
`define I2CS_MODE_BUS 2'h2
`define I2CS_CR2_EN 1
`define I2CS_CR4_IFR 7
`define I2CS_CR4_HOLD_OFF 5
`define I2CS_CR4_IE 4
`define I2CS_CR4_ACK 3
`define I2CS_SAR_GCE 0
`define I2CS_GCALL_ADDR 8'h00

// Bus timing
`define I2CS_BITS_PER_BYTE 4'h8
`define I2CS_RATE_ADD 10'h004

`endif

// ### i2cs_pkg.sv
package i2cs_pkg;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } i2cs_bus_req_type;

  // Open-drain pin drive, enable high while pulling low
  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } i2cs_pin_drive_type;

  // Slave sequencer states
  typedef enum logic [3:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_HOLD,
    S_TX_BYTE,
    S_TX_ACK,
    S_RX_BYTE,
    S_RX_ACK,
    S_WAIT_STOP,
    S_STOPPED
  } i2cs_state_type;

endpackage : i2cs_pkg

// ### i2cs_sync.sv
`timescale 1ns/10ps
module i2cs_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous levels and their synchronised copy
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // First stage, read only by the second
  logic [WIDTH-1:0] meta_q;

  // Two-flop synchroniser
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '1;
      q <= '1;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : i2cs_sync

// ### i2cs_top.sv
`timescale 1ns/10ps
`include "i2cs_regs.svh"
module i2cs_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire i2cs_pkg::i2cs_bus_req_type bus_req,
  output logic [7:0] rd_data,
  // Bus pins
  input wire logic bus_clock_pin_level,
  input wire logic bus_data_pin_level,
  output i2cs_pkg::i2cs_pin_drive_type pin_drive,
  // Events and rate
  output logic irq,
  output logic rate_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0] rst_pipe_q; // Reset release pipe
  logic rst_sync_n; // Released reset
  logic [7:0] ctrl1_q, ctrl2_q, ctrl3_q, ctrl4_q; // Control bytes
  logic [7:0] sar_q; // Own address and general call enable
  logic [7:0] stat1_q; // Plain storage for other modes
  logic [7:0] baud_q, hold_q, scll_q, sclh_q; // Timing settings
  logic [7:0] tx_buf_q; // Transmit buffer
  logic [7:0] rx_buf_q; // Receive buffer
  logic [7:0] rd_data_q; // Read data
  logic gcall_q, tend_q, stopd_q, ssel_q; // Sticky events
  logic tmode_q, rxack_q, busy_q, nack_q; // Transfer state
  logic irq_q; // Interrupt output
  logic [1:0] pins_s; // Synchronised pin levels
  logic scl_p_q, sda_p_q; // Previous synchronised levels
  logic scl_s, sda_s; // Current synchronised levels
  logic rise, fall, start_cond, stop_cond; // Bus events
  logic bus_on; // Unit enabled in bus mode
  logic st2_wr; // Status-2 write strobe
  logic addr_done, own_hit, gc_hit; // Address decision
  logic ev_ssel, ev_tend, ev_stop; // Event pulses
  logic [7:0] hold_eff; // Effective hold count
  i2cs_pkg::i2cs_state_type state_q; // Sequencer state
  logic [3:0] bit_cnt_q; // Bits this byte
  logic [7:0] shift_q; // Shift register
  logic scl_oe_q; // Clock stretch
  logic sda_req_q, sda_req_low_q, sda_req_now_q; // Data drive request
  logic sda_pend_q, sda_want_q, sda_oe_q; // Delayed data drive
  logic [7:0] hold_cnt_q; // Hold countdown
  logic [11:0] rate_cnt_q; // Rate counter
  logic [11:0] rate_period; // Rate period in cycles
  logic rate_tick_q; // Rate pulse

  // Register address hit
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_pipe_q <= 2'h0;
    else
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
  end
  assign rst_sync_n = rst_pipe_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling; pins read only through the input latch
  i2cs_sync #(.WIDTH(2)) u_sync (
    .clk(clk),
    .rst_n(rst_sync_n),
    .d({bus_clock_pin_level, bus_data_pin_level}),
    .q(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Previous levels for edge and condition detection
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Edges and START/STOP while clock stays high
  assign rise = scl_s & ~scl_p_q;
  assign fall = ~scl_s & scl_p_q;
  assign start_cond = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_cond = scl_s & scl_p_q & ~sda_p_q & sda_s;
  // Software must program mode and enable first
  assign bus_on = ctrl2_q[`I2CS_CR2_EN] & (ctrl1_q[`I2CS_CR1_MODE_HI:`I2CS_CR1_MODE_LO] == `I2CS_MODE_BUS);
  assign st2_wr = bus_req.wr & reg_hit(bus_req.addr, `I2CS_OFS_STAT2);
  // Hold disable bit forces zero; slow clocks need zero
  assign hold_eff = ctrl4_q[`I2CS_CR4_HOLD_OFF] ? 8'h00 : hold_q;

  // Address decision on the eighth falling edge
  assign addr_done = (state_q == i2cs_pkg::S_ADDR) & fall & (bit_cnt_q == `I2CS_BITS_PER_BYTE);
  assign own_hit = (shift_q[7:1] == sar_q[7:1]);
  assign gc_hit = sar_q[`I2CS_SAR_GCE] & (shift_q == `I2CS_GCALL_ADDR);

  // Event pulses
  assign ev_ssel = (state_q == i2cs_pkg::S_ADDR_ACK) & fall & ~start_cond & ~stop_cond;
  assign ev_tend = ((state_q == i2cs_pkg::S_TX_ACK) | (state_q == i2cs_pkg::S_RX_ACK)) & fall;
  assign ev_stop = bus_on & stop_cond & (state_q != i2cs_pkg::S_IDLE) & (state_q != i2cs_pkg::S_ADDR)
                   & (state_q != i2cs_pkg::S_STOPPED);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ctrl1_q <= `I2CS_RST_CTRL;
      ctrl2_q <= `I2CS_RST_CTRL;
      ctrl3_q <= `I2CS_RST_CTRL;
      ctrl4_q <= `I2CS_RST_CTRL;
      sar_q <= `I2CS_RST_SAR;
      stat1_q <= `I2CS_RST_STAT1;
      baud_q <= `I2CS_RST_BAUD;
      hold_q <= `I2CS_RST_HOLD;
      tx_buf_q <= `I2CS_RST_DATA;
      scll_q <= `I2CS_RST_SCLP;
      sclh_q <= `I2CS_RST_SCLP;
    end
    else if (bus_req.wr)
    begin
      case (bus_req.addr)
        `I2CS_OFS_CTRL1: ctrl1_q <= bus_req.wdata;
        `I2CS_OFS_CTRL2: ctrl2_q <= bus_req.wdata;
        `I2CS_OFS_CTRL3: ctrl3_q <= bus_req.wdata;
        `I2CS_OFS_CTRL4: ctrl4_q <= bus_req.wdata;
        `I2CS_OFS_SAR: sar_q <= bus_req.wdata;
        `I2CS_OFS_STAT1: stat1_q <= bus_req.wdata;
        `I2CS_OFS_BAUD: baud_q <= bus_req.wdata;
        `I2CS_OFS_HOLD: hold_q <= bus_req.wdata;
        `I2CS_OFS_DATA: tx_buf_q <= bus_req.wdata; // Writes land in transmit buffer only
        `I2CS_OFS_SCLL: scll_q <= bus_req.wdata;
        `I2CS_OFS_SCLH: sclh_q <= bus_req.wdata;
        default: ;
      endcase
    end
  end

  // Read data stand for exactly one cycle; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      rd_data_q <= 8'h00;
    else if (!bus_req.rd)
      rd_data_q <= 8'h00;
    else
    begin
      case (bus_req.addr)
        `I2CS_OFS_CTRL1: rd_data_q <= ctrl1_q;
        `I2CS_OFS_CTRL2: rd_data_q <= ctrl2_q;
        `I2CS_OFS_CTRL3: rd_data_q <= ctrl3_q;
        // Reserved bit six reads zero; slave-only unit shows master bit zero
        `I2CS_OFS_CTRL4: rd_data_q <= {irq_q, 1'b0, ctrl4_q[5:3], 1'b0, ctrl4_q[1:0]};
        `I2CS_OFS_SAR: rd_data_q <= sar_q;
        `I2CS_OFS_STAT1: rd_data_q <= stat1_q;
        `I2CS_OFS_STAT2: rd_data_q <= {gcall_q, tend_q, stopd_q, ssel_q, 1'b0, busy_q, tmode_q, rxack_q};
        `I2CS_OFS_BAUD: rd_data_q <= baud_q;
        `I2CS_OFS_HOLD: rd_data_q <= hold_q;
        `I2CS_OFS_DATA: rd_data_q <= rx_buf_q; // Reads return receive buffer
        `I2CS_OFS_SCLL: rd_data_q <= scll_q;
        `I2CS_OFS_SCLH: rd_data_q <= sclh_q;
        default: rd_data_q <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events; any write to status 2 clears, a same-cycle set wins
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      gcall_q <= 1'b0;
      tend_q <= 1'b0;
      stopd_q <= 1'b0;
      ssel_q <= 1'b0;
    end
    else
    begin
      if (st2_wr)
      begin
        gcall_q <= 1'b0;
        tend_q <= 1'b0;
        stopd_q <= 1'b0;
        ssel_q <= 1'b0;
      end
      if (addr_done & ctrl4_q[`I2CS_CR4_ACK] & gc_hit)
        gcall_q <= 1'b1;
      if (ev_ssel)
        ssel_q <= 1'b1;
      if (ev_tend)
        tend_q <= 1'b1;
      if (ev_stop)
        stopd_q <= 1'b1;
    end
  end

  // Interrupt request from pending events
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      irq_q <= 1'b0;
    else
      irq_q <= bus_on & ctrl4_q[`I2CS_CR4_IE] & (ssel_q | tend_q | stopd_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave sequencer
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_q <= i2cs_pkg::S_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      scl_oe_q <= 1'b0;
      sda_req_q <= 1'b0;
      sda_req_low_q <= 1'b0;
      sda_req_now_q <= 1'b0;
      tmode_q <= 1'b0;
      rxack_q <= 1'b0;
      busy_q <= 1'b0;
      nack_q <= 1'b0;
      rx_buf_q <= `I2CS_RST_DATA;
    end
    else
    begin
      sda_req_q <= 1'b0;
      sda_req_now_q <= 1'b0;
      if (!bus_on)
      begin
        // Unit off: let both lines go
        state_q <= i2cs_pkg::S_IDLE;
        scl_oe_q <= 1'b0;
        busy_q <= 1'b0;
        sda_req_q <= 1'b1;
        sda_req_low_q <= 1'b0;
        sda_req_now_q <= 1'b1;
      end
      else if (stop_cond)
      begin
        // STOP ends any transfer; addressed ones wait for software
        busy_q <= 1'b0;
        scl_oe_q <= 1'b0;
        sda_req_q <= 1'b1;
        sda_req_low_q <= 1'b0;
        sda_req_now_q <= 1'b1;
        if (ev_stop)
          state_q <= i2cs_pkg::S_STOPPED;
        else if (state_q != i2cs_pkg::S_STOPPED)
          state_q <= i2cs_pkg::S_IDLE;
      end
      else if (start_cond)
      begin
        // START or repeated START from any state
        busy_q <= 1'b1;
        scl_oe_q <= 1'b0;
        sda_req_q <= 1'b1;
        sda_req_low_q <= 1'b0;
        sda_req_now_q <= 1'b1;
        bit_cnt_q <= 4'h0;
        state_q <= i2cs_pkg::S_ADDR;
      end
      else
      begin
        case (state_q)
          i2cs_pkg::S_IDLE: ;
          i2cs_pkg::S_ADDR:
          begin
            if (rise)
            begin
              shift_q <= {shift_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            else if (addr_done)
            begin
              if ((own_hit | gc_hit) & ctrl4_q[`I2CS_CR4_ACK])
              begin
                tmode_q <= shift_q[0];
                sda_req_q <= 1'b1;
                sda_req_low_q <= 1'b1;
                state_q <= i2cs_pkg::S_ADDR_ACK;
              end
              else
                state_q <= i2cs_pkg::S_IDLE;
            end
          end
          i2cs_pkg::S_ADDR_ACK:
          begin
            if (fall)
            begin
              scl_oe_q <= 1'b1;
              nack_q <= 1'b0;
              sda_req_q <= 1'b1;
              sda_req_low_q <= 1'b0;
              state_q <= i2cs_pkg::S_HOLD;
            end
          end
          i2cs_pkg::S_HOLD:
          begin
            if (st2_wr)
            begin
              scl_oe_q <= 1'b0; // Any value written releases
              bit_cnt_q <= 4'h0;
              if (nack_q)
                state_q <= i2cs_pkg::S_WAIT_STOP;
              else if (tmode_q)
              begin
                // Transmit byte must already sit in the buffer
                shift_q <= tx_buf_q;
                sda_req_q <= 1'b1;
                sda_req_low_q <= ~tx_buf_q[7];
                sda_req_now_q <= 1'b1;
                state_q <= i2cs_pkg::S_TX_BYTE;
              end
              else
                state_q <= i2cs_pkg::S_RX_BYTE;
            end
          end
          i2cs_pkg::S_TX_BYTE:
          begin
            if (rise)
              bit_cnt_q <= bit_cnt_q + 4'h1;
            else if (fall)
            begin
              sda_req_q <= 1'b1;
              if (bit_cnt_q == `I2CS_BITS_PER_BYTE)
              begin
                sda_req_low_q <= 1'b0;
                state_q <= i2cs_pkg::S_TX_ACK;
              end
              else
              begin
                shift_q <= {shift_q[6:0], 1'b0};
                sda_req_low_q <= ~shift_q[6];
              end
            end
          end
          i2cs_pkg::S_TX_ACK:
          begin
            if (rise)
              rxack_q <= ~sda_s;
            else if (fall)
            begin
              scl_oe_q <= 1'b1;
              nack_q <= ~rxack_q; // Master nack ends sending
              state_q <= i2cs_pkg::S_HOLD;
            end
          end
          i2cs_pkg::S_RX_BYTE:
          begin
            if (rise)
            begin
              shift_q <= {shift_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            else if (fall & (bit_cnt_q == `I2CS_BITS_PER_BYTE))
            begin
              rx_buf_q <= shift_q;
              sda_req_q <= 1'b1;
              sda_req_low_q <= ctrl4_q[`I2CS_CR4_ACK];
              nack_q <= ~ctrl4_q[`I2CS_CR4_ACK];
              state_q <= i2cs_pkg::S_RX_ACK;
            end
          end
          i2cs_pkg::S_RX_ACK:
          begin
            if (fall)
            begin
              sda_req_q <= 1'b1;
              sda_req_low_q <= 1'b0;
              scl_oe_q <= 1'b1;
              state_q <= i2cs_pkg::S_HOLD;
            end
          end
          i2cs_pkg::S_WAIT_STOP: ;
          i2cs_pkg::S_STOPPED:
          begin
            if (st2_wr)
              state_q <= i2cs_pkg::S_IDLE;
          end
          default: state_q <= i2cs_pkg::S_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data line drive, delayed by the hold count after a request; immediate requests bypass the delay
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      sda_pend_q <= 1'b0;
      sda_want_q <= 1'b0;
      sda_oe_q <= 1'b0;
      hold_cnt_q <= 8'h00;
    end
    else if (sda_req_q & sda_req_now_q)
    begin
      sda_oe_q <= sda_req_low_q;
      sda_pend_q <= 1'b0;
    end
    else if (sda_req_q)
    begin
      sda_pend_q <= 1'b1;
      sda_want_q <= sda_req_low_q;
      hold_cnt_q <= hold_eff;
    end
    else if (sda_pend_q)
    begin
      if (hold_cnt_q == 8'h00)
      begin
        sda_oe_q <= sda_want_q;
        sda_pend_q <= 1'b0;
      end
      else
        hold_cnt_q <= hold_cnt_q - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus rate period for master timing: four times (sum plus four)
  assign rate_period = {({2'h0, scll_q} + {2'h0, sclh_q} + `I2CS_RATE_ADD), 2'h0};
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rate_cnt_q <= 12'h000;
      rate_tick_q <= 1'b0;
    end
    else if (!bus_on)
    begin
      rate_cnt_q <= 12'h000;
      rate_tick_q <= 1'b0;
    end
    else if (rate_cnt_q == 12'h000)
    begin
      rate_cnt_q <= rate_period - 12'h001;
      rate_tick_q <= 1'b1;
    end
    else
    begin
      rate_cnt_q <= rate_cnt_q - 12'h001;
      rate_tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; pins only ever pull low
  assign pin_drive = '{scl_o: 1'b0, scl_oe: scl_oe_q, sda_o: 1'b0, sda_oe: sda_oe_q};
  assign rd_data = rd_data_q;
  assign irq = irq_q;
  assign rate_tick = rate_tick_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  data_read_rx_a: assert property (bus_req.rd && bus_req.addr == `I2CS_OFS_DATA
    |=> rd_data == $past(rx_buf_q))
    else $error("data read did not return receive buffer");
  no_match_a: assert property (bus_on && !stop_cond && !start_cond && addr_done && !own_hit && !gc_hit
    |=> state_q == i2cs_pkg::S_IDLE)
    else $error("unmatched address not ignored");
  ack_off_a: assert property (bus_on && !stop_cond && !start_cond && addr_done && !ctrl4_q[`I2CS_CR4_ACK]
    |=> state_q == i2cs_pkg::S_IDLE && !sda_req_q)
    else $error("matched address answered without ack enable");
  addr_ack_a: assert property (bus_on && !stop_cond && !start_cond && addr_done && own_hit && ctrl4_q[`I2CS_CR4_ACK]
    |=> state_q == i2cs_pkg::S_ADDR_ACK && sda_req_q && sda_req_low_q)
    else $error("own address not acknowledged");
  gcall_set_a: assert property (bus_on && !stop_cond && !start_cond && addr_done && gc_hit && ctrl4_q[`I2CS_CR4_ACK]
    |=> gcall_q ##1 state_q != i2cs_pkg::S_ADDR)
    else $error("general call not flagged");
  ssel_stretch_a: assert property (bus_on && ev_ssel |=> ssel_q && scl_oe_q)
    else $error("selection without stretch");
  clk_release_a: assert property (bus_on && state_q == i2cs_pkg::S_HOLD && st2_wr |=> !scl_oe_q)
    else $error("status write did not release clock");
  tend_hold_a: assert property (bus_on && ev_tend && !st2_wr |=> tend_q && scl_oe_q [*1] ##1 tend_q)
    else $error("byte end not flagged with stretch");
  restart_addr_a: assert property (bus_on && start_cond && !stop_cond
    |=> state_q == i2cs_pkg::S_ADDR && bit_cnt_q == 4'h0)
    else $error("repeated start not taken");
  stop_flag_a: assert property (ev_stop |=> stopd_q && state_q == i2cs_pkg::S_STOPPED)
    else $error("stop not flagged");
  hold_zero_a: assert property (sda_req_q && !sda_req_now_q && hold_eff == 8'h00 ##1 !sda_req_q
    |=> sda_oe_q == $past(sda_req_low_q, 2))
    else $error("data change not after hold count");
  irq_pending_a: assert property ($rose(ssel_q) && bus_on && ctrl4_q[`I2CS_CR4_IE] && $stable(ctrl4_q) |=> irq_q)
    else $error("pending event without interrupt");

  sel_cov_c: cover property (ev_ssel ##[1:1000] st2_wr);
  tx_cov_c: cover property (state_q == i2cs_pkg::S_TX_ACK ##1 state_q == i2cs_pkg::S_HOLD);
  rx_cov_c: cover property (state_q == i2cs_pkg::S_RX_ACK ##1 state_q == i2cs_pkg::S_HOLD);
  stop_cov_c: cover property (ev_stop);

endmodule : i2cs_top

// ### i2cs_bus_master.sv
`timescale 1ns/10ps
// Far-side bus master; drives both wires open-drain, never high
module i2cs_bus_master (
  // Clock and wire levels
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  // Pull-low enables and hang flag
  output logic scl_oe,
  output logic sda_oe,
  output logic hung
);
  localparam int HALF = 8; // Half of a 64 ns bit period
  initial
  begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    hung = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Half a bit time
  task automatic half_bit();
    repeat (HALF) @(posedge clk);
  endtask : half_bit
  // Release the clock and honour a slave stretch, bounded
  task automatic rise_clk();
    int n = 0;
    scl_oe <= 1'b0;
    while (scl !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000)
      hung <= 1'b1;
    half_bit();
  endtask : rise_clk
  // One bit: data moves only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    sda_oe <= !b;
    half_bit();
    rise_clk();
    s = sda;
    scl_oe <= 1'b1;
  endtask : bit_io
  // START or repeated START: data falls while clock high
  task automatic start();
    sda_oe <= 1'b0;
    half_bit();
    rise_clk();
    sda_oe <= 1'b1;
    half_bit();
    scl_oe <= 1'b1;
  endtask : start
  // STOP: data rises while clock high
  task automatic stop();
    sda_oe <= 1'b1;
    half_bit();
    rise_clk();
    sda_oe <= 1'b0;
    half_bit();
  endtask : stop
  // Byte MSB first, then the ninth bit; a nack from here ends a read
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ack_in, ack);
    // Let the slave see the ninth fall and stretch before software looks
    repeat (6) @(posedge clk);
  endtask : xfer
endmodule : i2cs_bus_master

// ### i2c_slave_with_register_bank_tb.sv
`timescale 1ns/10ps
module i2c_slave_with_register_bank_tb;
  logic clk;
  logic rst_n;
  i2cs_pkg::i2cs_bus_req_type bus_req;
  logic [7:0] rd_data;
  i2cs_pkg::i2cs_pin_drive_type pin_drive;
  logic irq;
  logic rate_tick;
  logic m_scl_oe;
  logic m_sda_oe;
  logic hung;
  int err_count = 0;
  int n_checks = 0;
  logic [7:0] q;
  logic a;
  int n;
  // Offsets with reset values; the last one is unmapped and reads 0
  logic [7:0] ofs [13] = '{8'hD9, 8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE6, 8'hE7, 8'hE0};
  logic [7:0] rst [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'hFF, 8'h01, 8'h00, 8'h3F, 8'h3F, 8'h00};
  // Pull-ups: a wire is low while any party pulls it
  wire scl = !(m_scl_oe | pin_drive.scl_oe);
  wire sda = !(m_sda_oe | pin_drive.sda_oe);
  i2cs_top DUT (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data), .bus_clock_pin_level(scl),
    .bus_data_pin_level(sda), .pin_drive(pin_drive), .irq(irq), .rate_tick(rate_tick));
  i2cs_bus_master m (.clk(clk), .scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .hung(hung));
  ////////////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  // Byte comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One-cycle write strobe
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    bus_req.wr <= 1'b1;
    bus_req.addr <= ad;
    bus_req.wdata <= d;
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr
  // One-cycle read strobe; data stands in the following cycle only
  task automatic rchk(input logic [7:0] ad, input logic [7:0] mask, input logic [7:0] exp);
    @(posedge clk);
    bus_req.rd <= 1'b1;
    bus_req.addr <= ad;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 chk(rd_data & mask, exp);
  endtask : rchk
  // START plus address byte, with the expected ninth bit
  task automatic addr_phase(input logic [7:0] ad, input logic nack);
    m.start();
    m.xfer(ad, 1'b1, q, a);
    chk(a, nack);
  endtask : addr_phase
  // A hung bus counts against the run
  always @(posedge hung)
  begin
    err_count++;
    finish_test();
  end
  // Overall bound on the run
  initial
  begin
    #300000;
    err_count++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    bus_req = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (ofs[i]) rchk(ofs[i], 8'hFF, rst[i]);
    wr(8'hE5, 8'h5A);
    rchk(8'hE5, 8'hFF, 8'h00);
    // Fast rate, zero hold, own address 0x52, ack and irq on, bus mode, unit on
    wr(8'hE6, 8'h01);
    wr(8'hE7, 8'h01);
    wr(8'hE4, 8'h00);
    wr(8'hDD, 8'hA4);
    wr(8'hDC, 8'h18);
    wr(8'hD9, 8'h80);
    wr(8'hDA, 8'h02);
    // Rate pulse spacing: 4 * (1 + 1 + 4)
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end while (rate_tick !== 1'b1 && n < 100);
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end while (rate_tick !== 1'b1 && n < 100);
    chk(n[7:0], 8'd24);
    // Slave receive: address, one byte, STOP
    addr_phase(8'hA4, 1'b0);
    rchk(8'hE2, 8'hF0, 8'h10);
    chk(irq, 1'b1);
    wr(8'hE2, 8'h5B);
    m.xfer(8'h3C, 1'b1, q, a);
    chk(a, 1'b0);
    rchk(8'hE2, 8'hFF, 8'h44);
    rchk(8'hE5, 8'hFF, 8'h3C);
    wr(8'hE2, 8'h00);
    m.stop();
    rchk(8'hE2, 8'hF0, 8'h20);
    wr(8'hE2, 8'hFF);
    rchk(8'hE2, 8'hF0, 8'h00);
    chk(irq, 1'b0);
    // Foreign address: no acknowledge, STOP leaves no flag
    addr_phase(8'hA6, 1'b1);
    m.stop();
    rchk(8'hE2, 8'hF0, 8'h00);
    // Slave transmit, master nack, then repeated START
    addr_phase(8'hA5, 1'b0);
    wr(8'hE5, 8'hC3);
    wr(8'hE2, 8'h00);
    m.xfer(8'hFF, 1'b1, q, a);
    chk(q, 8'hC3);
    rchk(8'hE2, 8'hFF, 8'h46);
    wr(8'hE2, 8'h00);
    addr_phase(8'hA4, 1'b0);
    wr(8'hE2, 8'h00);
    m.stop();
    wr(8'hE2, 8'h00);
    // General call accepted once enabled
    wr(8'hDD, 8'hA5);
    addr_phase(8'h00, 1'b0);
    rchk(8'hE2, 8'h80, 8'h80);
    wr(8'hE2, 8'h00);
    m.stop();
    wr(8'hE2, 8'h00);
    // Own address while acknowledge generation is off
    wr(8'hDC, 8'h10);
    addr_phase(8'hA4, 1'b1);
    m.stop();
    rchk(8'hE2, 8'hF0, 8'h00);
    finish_test();
  end
endmodule : i2c_slave_with_register_bank_tb
